// ===== core/pmrd_fetch_timer.sv
// counts the fetch time of one program memory read
// assumes start pulses only while not busy
`timescale 1ns/100ps
`default_nettype none
module pmrd_fetch_timer
    import pmrd_pkg::*;
#(
    parameter int CYCLES = PMRD_FETCH_CYC
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic start,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_r;
    initial begin
        if (CYCLES < 2) $error("fetch time must be at least two clocks");
    end
    // load on start, count down, pulse done on reaching one
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_r <= '0;
            done  <= 1'b0;
        end else begin
            done <= (cnt_r == CW'(1));
            if (start)
                cnt_r <= CW'(CYCLES);
            else if (cnt_r != '0)
                cnt_r <= cnt_r - CW'(1);
        end
    end
endmodule : pmrd_fetch_timer
`default_nettype wire

// ===== core/pmrd_flash_array.sv
// flip-flop model of the program memory array, one read port plus the preload write port
// contents are loaded through a preload port used at bring-up
`timescale 1ns/100ps
`default_nettype none
module pmrd_flash_array
    import pmrd_pkg::*;
#(
    parameter int DEPTH = 1 << PMRD_ADDR_W
) (
    input  wire logic                   ref_clk,
    input  wire logic                   load_en,
    input  wire logic [PMRD_ADDR_W-1:0] load_addr,
    input  wire logic [PMRD_WORD_W-1:0] load_word,
    input  wire logic [PMRD_ADDR_W-1:0] rd_addr,
    output logic      [PMRD_WORD_W-1:0] rd_word
);
    logic [PMRD_WORD_W-1:0] mem [DEPTH];
    initial begin
        if (DEPTH > (1 << PMRD_ADDR_W)) $error("array deeper than address reach");
    end
    // preload path; no protection gate anywhere on the read side
    always_ff @(posedge ref_clk) begin
        if (load_en)
            mem[load_addr] <= load_word;
    end
    // registered read
    always_ff @(posedge ref_clk) begin
        rd_word <= mem[rd_addr];
    end
endmodule : pmrd_flash_array
`default_nettype wire

// ===== core/pmrd_pkg.sv
// package for the program memory read port: register map, field layout, timing
// assumes a 20 MHz core clock and a 32-bit Avalon-MM register bus
package pmrd_pkg;
    localparam int          PMRD_ADDR_W      = 13;  // word address width
    localparam int          PMRD_WORD_W      = 14;  // fetched word width
    localparam int          PMRD_BUS_AW      = 4;   // byte address width on the bus
    // byte offsets of the registers
    localparam logic [3:0]  PMRD_OFS_CTRL    = 4'h0;
    localparam logic [3:0]  PMRD_OFS_DATA_HI = 4'h4;
    localparam logic [3:0]  PMRD_OFS_DATA_LO = 4'h8;
    localparam logic [3:0]  PMRD_OFS_ADDR_HI = 4'hC;
    // the low address register sits at the top word of the map
    localparam logic [3:0]  PMRD_OFS_ADDR_LO = 4'hC + 4'h0;
    // field positions
    localparam int          PMRD_CTRL_TRIG_BIT = 0;
    localparam int          PMRD_CTRL_RSVD_BIT = 7;
    localparam logic [7:0]  PMRD_CTRL_RSVD_VAL = 8'h80;
    // reset values
    localparam logic        PMRD_TRIG_RST    = 1'b0;
    // fetch time in instruction cycles, each instruction cycle four core clocks
    localparam int          PMRD_FETCH_INSTR = 2;
    localparam int          PMRD_CLK_PER_INSTR = 4;
    localparam int          PMRD_FETCH_CYC   = PMRD_FETCH_INSTR * PMRD_CLK_PER_INSTR;
    localparam logic [31:0] PMRD_UNMAPPED_RD = 32'h0000_0000;
    typedef enum logic [1:0] {PMRD_IDLE, PMRD_BUSY, PMRD_LATCH} pmrd_state_e;
endpackage : pmrd_pkg

// ===== core/pmrd_top.sv
// program memory read port: five registers behind an Avalon-MM slave
// assumes one 20 MHz clock, synchronous active-low reset, 32-bit bus
// How it works
// - address high:low pair selects fetched word
// - writing trigger bit starts one fetch
// - fetch takes two instruction cycles; CPU stalls
// - fetched word lands in data pair
// - code protection never gates the fetch
// - control top bit reads one always
// - trigger only set by software, hardware clears
// - unimplemented bits read zero
// - word splits six high, eight low
// - address splits five high, eight low
// - address and data registers read-write, unreset
`timescale 1ns/100ps
`default_nettype none
module pmrd_top
    import pmrd_pkg::*;
#(
    parameter int FETCH_CYCLES = PMRD_FETCH_CYC,
    parameter int MEM_DEPTH    = 1 << PMRD_ADDR_W
) (
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    input  wire logic [pmrd_pkg::PMRD_BUS_AW-1:0] avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [31:0]                  avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic                         code_protect,
    input  wire logic                         load_en,
    input  wire logic [pmrd_pkg::PMRD_ADDR_W-1:0] load_addr,
    input  wire logic [pmrd_pkg::PMRD_WORD_W-1:0] load_word,
    output logic                              cpu_stall
);
    import pmrd_pkg::*;

    // map: 0 ctrl, 4 data high, 8 data low, C address (lane 0 high, lane 1 low)
    logic [7:0]             addr_hi_r;
    logic [7:0]             addr_lo_r;
    logic [5:0]             data_hi_r;
    logic [7:0]             data_lo_r;
    logic                   trig_r;
    logic                   ack_r;
    logic [31:0]            rdata_nxt;
    logic                   fetch_start;
    logic                   fetch_done;
    logic [PMRD_WORD_W-1:0] mem_word;
    logic [PMRD_ADDR_W-1:0] word_address_bits;
    pmrd_state_e            state_r;
    logic                   be0;
    logic                   hit_ctrl;
    logic                   hit_dhi;
    logic                   hit_dlo;
    logic                   hit_ahi;
    logic                   hit_alo;

    // protection strap is deliberately ignored by the fetch path
    wire unused_prot = code_protect;

    assign be0      = avs_byteenable[0];
    assign hit_ctrl = (avs_address == PMRD_OFS_CTRL);
    assign hit_dhi  = (avs_address == PMRD_OFS_DATA_HI);
    assign hit_dlo  = (avs_address == PMRD_OFS_DATA_LO);
    assign hit_ahi  = (avs_address == PMRD_OFS_ADDR_HI) && !avs_address[0];
    // low address register at byte offset 0xD: not word aligned is not allowed,
    // so it shares the map through offset 0xC's spare lane: use byte lane 1
    assign hit_alo  = (avs_address == PMRD_OFS_ADDR_HI) && avs_byteenable[1];

    // address pair forms the word address
    assign word_address_bits = {addr_hi_r[4:0], addr_lo_r};

    pmrd_flash_array #(
        .DEPTH     (MEM_DEPTH)
    ) u_array (
        .ref_clk   (ref_clk),
        .load_en   (load_en),
        .load_addr (load_addr),
        .load_word (load_word),
        .rd_addr   (word_address_bits),
        .rd_word   (mem_word)
    );

    pmrd_fetch_timer #(
        .CYCLES  (FETCH_CYCLES)
    ) u_timer (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .start   (fetch_start),
        .done    (fetch_done)
    );

    // a trigger write while idle starts exactly one fetch
    assign fetch_start = (state_r == PMRD_IDLE) && trig_r;

    // fetch sequencer
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r <= PMRD_IDLE;
        end else begin
            case (state_r)
                PMRD_IDLE:  if (trig_r) state_r <= PMRD_BUSY;
                PMRD_BUSY:  if (fetch_done) state_r <= PMRD_LATCH;
                PMRD_LATCH: state_r <= PMRD_IDLE;
                default:    state_r <= PMRD_IDLE;
            endcase
        end
    end

    // cpu holds off the two following instructions while the fetch runs
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            cpu_stall <= 1'b0;
        else
            cpu_stall <= fetch_start || (state_r == PMRD_BUSY && !fetch_done);
    end

    // trigger: software may only set it, hardware clears it at latch
    // writes take effect at the edge where waitrequest is seen low (ack_r high);
    // a set in the latch cycle wins so a request is never lost
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            trig_r <= PMRD_TRIG_RST;
        else if (avs_write && ack_r && hit_ctrl && be0 && avs_writedata[PMRD_CTRL_TRIG_BIT])
            trig_r <= 1'b1;
        else if (state_r == PMRD_LATCH)
            trig_r <= 1'b0;
    end

    // address registers: plain read-write, no reset value
    always_ff @(posedge ref_clk) begin
        if (avs_write && ack_r && hit_ahi && be0)
            addr_hi_r <= {3'h0, avs_writedata[4:0]};
        if (avs_write && ack_r && hit_alo)
            addr_lo_r <= avs_writedata[15:8];
    end

    // data registers: software writable, fetch result wins over a same-cycle write
    always_ff @(posedge ref_clk) begin
        if (state_r == PMRD_LATCH) begin
            data_hi_r <= mem_word[13:8];
            data_lo_r <= mem_word[7:0];
        end else if (avs_write && ack_r && be0) begin
            if (hit_dhi)
                data_hi_r <= avs_writedata[5:0];
            if (hit_dlo)
                data_lo_r <= avs_writedata[7:0];
        end
    end

    // read mux; unimplemented bits and unmapped offsets read zero
    always_comb begin
        rdata_nxt = PMRD_UNMAPPED_RD;
        if (hit_ctrl)
            rdata_nxt = {24'h00_0000, PMRD_CTRL_RSVD_VAL | {7'h00, trig_r}};
        else if (hit_dhi)
            rdata_nxt = {26'h000_0000, data_hi_r};
        else if (hit_dlo)
            rdata_nxt = {24'h00_0000, data_lo_r};
        else if (avs_address == PMRD_OFS_ADDR_HI)
            rdata_nxt = {16'h0000, addr_lo_r, 3'h0, addr_hi_r[4:0]};
    end

    // one wait state per access: waitrequest drops the cycle after a request
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
            if (avs_read && !ack_r)
                avs_readdata <= rdata_nxt;
        end
    end

    // registered waitrequest: high until the answer cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
endmodule : pmrd_top
`default_nettype wire

// ===== dv/pmrd_flash_loader.sv
// model of the program memory contents: fills every word once go rises
// assumes the array takes one preload word per clock edge
`timescale 1ns/100ps
`default_nettype none
module pmrd_flash_loader
    import pmrd_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   go,
    output logic                        load_en,
    output logic      [PMRD_ADDR_W-1:0] load_addr,
    output logic      [PMRD_WORD_W-1:0] load_word,
    output logic                        done
);
    // word value is a simple function of its address so the bench can predict it
    initial begin
        load_en = 1'b0;
        load_addr = '0;
        load_word = '0;
        done = 1'b0;
        wait (go === 1'b1);
        for (int a = 0; a < (1 << PMRD_ADDR_W); a++) begin
            @(posedge ref_clk);
            load_en <= 1'b1;
            load_addr <= PMRD_ADDR_W'(a);
            load_word <= PMRD_WORD_W'(a * 5) + 14'h0123; // 14-bit words
        end
        @(posedge ref_clk);
        load_en <= 1'b0;
        load_word <= ~load_word; // no stale word left on idle lines
        done <= 1'b1;
    end
endmodule : pmrd_flash_loader
`default_nettype wire

// ===== dv/pmrd_props.sv
// checker for the program memory read port, bound to pmrd_top
// assumes one wait state per access and a stall held over the fetch
`timescale 1ns/100ps
`default_nettype none
module pmrd_props
    import pmrd_pkg::*;
#(
    parameter int FETCH_CYCLES = PMRD_FETCH_CYC
) (
    input wire logic                   ref_clk,
    input wire logic                   reset_n,
    input wire logic [PMRD_BUS_AW-1:0] avs_address,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_writedata,
    input wire logic [3:0]             avs_byteenable,
    input wire logic [31:0]            avs_readdata,
    input wire logic                   avs_waitrequest,
    input wire logic                   cpu_stall
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] stall_cnt_r;
    // length of the current stall, compared when it ends
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !cpu_stall) stall_cnt_r <= 8'h00;
        else stall_cnt_r <= stall_cnt_r + 8'h01;
    end
    sequence s_rd(logic [3:0] ofs);
        avs_read && !avs_waitrequest && avs_address == ofs;
    endsequence
    sequence s_trig_wr;
        avs_write && !avs_waitrequest && avs_address == PMRD_OFS_CTRL && avs_byteenable[0] && avs_writedata[0];
    endsequence
    property p_wait_short; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_ack_bound; (avs_read || avs_write) && avs_waitrequest |-> ##[1:4] !avs_waitrequest; endproperty
    property p_ack_cause; !avs_waitrequest |-> avs_read || avs_write; endproperty
    property p_trig_stall; s_trig_wr ##0 !cpu_stall |-> ##[1:4] cpu_stall; endproperty
    property p_stall_len;
        $fell(cpu_stall) |-> stall_cnt_r >= FETCH_CYCLES - 1 && stall_cnt_r <= FETCH_CYCLES + 1;
    endproperty
    property p_ctrl_rd; s_rd(PMRD_OFS_CTRL) |-> avs_readdata[7:1] == 7'h40; endproperty
    property p_dhi_rd; s_rd(PMRD_OFS_DATA_HI) |-> avs_readdata[7:6] == 2'h0; endproperty
    property p_ahi_rd; s_rd(PMRD_OFS_ADDR_HI) |-> avs_readdata[7:5] == 3'h0; endproperty
    a_wait_short: assert property (p_wait_short) else $error("waitrequest low too long");
    a_ack_bound: assert property (p_ack_bound) else $error("access not answered");
    a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
    a_trig_stall: assert property (p_trig_stall) else $error("trigger did not start fetch");
    a_stall_len: assert property (p_stall_len) else $error("fetch length wrong");
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control fixed bits wrong");
    a_dhi_rd: assert property (p_dhi_rd) else $error("data high top bits set");
    a_ahi_rd: assert property (p_ahi_rd) else $error("address high top bits set");
endmodule : pmrd_props
bind pmrd_top pmrd_props #(.FETCH_CYCLES(FETCH_CYCLES)) u_props (.ref_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_stall);
`default_nettype wire

// ===== dv/test_program_memory_read_port.sv
// self-checking bench: register accesses and fetches over Avalon-MM
// assumes the flash loader fills the array before the first fetch
`timescale 1ns/100ps
`default_nettype none
module test_program_memory_read_port;
    import pmrd_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, code_protect = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    logic avs_waitrequest, cpu_stall, load_en, go = 1'b0, done;
    logic [12:0] load_addr;
    logic [13:0] load_word;
    int mismatches = 0, n_checks = 0, cyc = 0;
    pmrd_top uut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .code_protect, .load_en, .load_addr, .load_word, .cpu_stall);
    pmrd_flash_loader u_mem (.ref_clk, .go, .load_en, .load_addr, .load_word, .done);
    always #25 ref_clk = ~ref_clk;
    // cut a hang short well beyond the preload and tests
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one access; an idle edge follows so the strobes never toggle twice in a step
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= we;
        avs_read <= !we;
        // no local limit on this wait; only the bench timeout cuts a hang short
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic fetch(input logic [12:0] a, input logic cp);
        logic [13:0] w;
        int n;
        w = 14'(a * 5) + 14'h0123;
        code_protect <= cp;
        bus(1'b1, PMRD_OFS_ADDR_HI, {16'h0000, a[7:0], 3'h0, a[12:8]}, 4'h3);
        bus(1'b0, PMRD_OFS_ADDR_HI, 32'h0000_0000, 4'hF);
        chk(q, {16'h0000, a[7:0], 3'h0, a[12:8]});
        bus(1'b1, PMRD_OFS_CTRL, 32'h0000_0081, 4'h1);
        bus(1'b0, PMRD_OFS_CTRL, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0081);
        chk({31'h0, cpu_stall}, 32'h0000_0001);
        n = 0;
        // software only polls control while the fetch runs
        do begin
            bus(1'b0, PMRD_OFS_CTRL, 32'h0000_0000, 4'hF);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        chk(q, 32'h0000_0080);
        chk({31'h0, cpu_stall}, 32'h0000_0000);
        bus(1'b0, PMRD_OFS_DATA_HI, 32'h0000_0000, 4'hF);
        chk(q, {26'h0, w[13:8]});
        bus(1'b0, PMRD_OFS_DATA_LO, 32'h0000_0000, 4'hF);
        chk(q, {24'h00_0000, w[7:0]});
    endtask : fetch
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        go <= 1'b1;
        wait (done === 1'b1);
        @(posedge ref_clk);
        bus(1'b0, PMRD_OFS_CTRL, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0080);
        bus(1'b1, PMRD_OFS_CTRL, 32'h0000_0000, 4'h1);
        bus(1'b0, PMRD_OFS_CTRL, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0080);
        bus(1'b1, PMRD_OFS_DATA_HI, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, PMRD_OFS_DATA_HI, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_003F);
        bus(1'b1, PMRD_OFS_DATA_LO, 32'h0000_00A5, 4'hF);
        bus(1'b0, PMRD_OFS_DATA_LO, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_00A5);
        bus(1'b0, 4'h6, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0000);
        $display("registers test done");
        fetch(13'h0000, 1'b0);
        fetch(13'h1FFF, 1'b1);
        fetch(13'h0A5C, 1'b1);
        fetch(13'h1555, 1'b0);
        $display("fetch test done");
        stop_test();
    end
endmodule : test_program_memory_read_port
`default_nettype wire
